// ==== nsa_defs.svh ====
// register offsets, field positions, encodings and reset values of the scanner arbiter
`ifndef NSA_DEFS_SVH
`define NSA_DEFS_SVH
`define NSA_ADDR_W 4
`define NSA_DATA_W 32
`define NSA_OFF_CTRL 4'h0
`define NSA_OFF_STAT 4'h4
`define NSA_CTRL_GO 0
`define NSA_CTRL_MODE_LO 1
`define NSA_CTRL_MODE_HI 2
`define NSA_CTRL_INTERRUPT_MODE_SELECT 3
`define NSA_CTRL_TSEL_LO 8
`define NSA_CTRL_TSEL_HI 11
`define NSA_STAT_BUSY 0
`define NSA_STAT_ARMED 1
`define NSA_STAT_STALL 2
`define NSA_STAT_ST_LO 4
`define NSA_STAT_ST_HI 7
`define NSA_TSEL_W 4
`define NSA_NTRIG 16
`define NSA_MODE_CONC 2'h0
`define NSA_MODE_BURST 2'h1
`define NSA_MODE_PEEK 2'h2
`define NSA_MODE_TRIG 2'h3
`define NSA_ST_IDLE 4'h1
`define NSA_ST_ARM 4'h2
`define NSA_ST_RUN 4'h4
`define NSA_ST_GAP 4'h8
`define NSA_RST_GO 1'h0
`define NSA_RST_MODE 2'h0
`define NSA_RST_INTERRUPT_MODE_SELECT 1'h0
`define NSA_RST_TSEL 4'h0
`define NSA_RST_WORD 32'h0000_0000
`define NSA_RST_TRIG 16'h0000
`endif

// ==== nsa_pkg.sv ====
// types of the scanner access arbiter
`include "nsa_defs.svh"
package nsa_pkg;
    typedef enum logic [1:0] {
        NSA_CONC = `NSA_MODE_CONC,
        NSA_BURST = `NSA_MODE_BURST,
        NSA_PEEK = `NSA_MODE_PEEK,
        NSA_TRIG = `NSA_MODE_TRIG
    } nsa_mode_t;
    typedef enum logic [3:0] {
        NSA_IDLE = `NSA_ST_IDLE,
        NSA_ARM = `NSA_ST_ARM,
        NSA_RUN = `NSA_ST_RUN,
        NSA_GAP = `NSA_ST_GAP
    } nsa_state_t;
    typedef struct packed {
        logic go;
        nsa_mode_t mode;
        logic interrupt_mode_select;
        logic [`NSA_TSEL_W-1:0] tsel;
        nsa_state_t st;
        logic [`NSA_NTRIG-1:0] trig_s1;
        logic [`NSA_NTRIG-1:0] trig_s2;
        logic trig_prev;
        logic ack;
        logic [`NSA_DATA_W-1:0] rdata;
    } nsa_regs_t;
endpackage

// ==== nsa_arbiter.sv ====
// scanner versus cpu access arbiter for the program nvm, with avalon-mm control registers
//
// What this block does
// - in burst mode the cpu is stalled from the cycle after the one that sets scan_go_a and the scan runs.
// - in burst mode the cpu stays held until a hardware end condition stops the scan.
// - in concurrent mode the cpu is stalled during each scan access and while ce is low, and runs between accesses.
// - in triggered mode the scan waits after scan_go_a for a rising edge of the selected trigger.
// - after the trigger edge the first access comes at once, stalling the cpu for each access and while ce is low.
// - in peek mode accesses use only cycles where the cpu does not need the nvm, never stalling it.
// - in peek mode the first access lands in the first dead cycle and the cpu keeps running after it.
// - with interrupt_mode_select at 1 an interrupt pauses the scan in every mode until it completes.
// - with interrupt_mode_select at 0 a burst holds the cpu through interrupts and other modes keep scanning.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module nsa_arbiter
    import nsa_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [`NSA_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [`NSA_DATA_W-1:0] writedata,
    output logic [`NSA_DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic [`NSA_NTRIG-1:0] trig_pins,
    input wire logic cpu_nvm_need,
    input wire logic irq_active,
    input wire logic scan_end,
    output logic cpu_stall,
    output logic scan_access
);
    logic [1:0] rst_ff;
    logic rst_n_s;
    nsa_regs_t s_q;
    nsa_regs_t s_d;
    logic req;
    logic wr_ctrl;
    logic trig_rise;
    logic pause;
    logic paired;

    function automatic logic hit(input logic [`NSA_ADDR_W-1:0] a, input logic [`NSA_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // reset released through two flops so removal is clean against clk
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_ff <= 2'h0;
        else
            rst_ff <= {rst_ff[0], 1'h1};
    end
    assign rst_n_s = rst_ff[1];

    always_comb
    begin
        s_d = s_q;
        req = read | write;
        wr_ctrl = write & s_q.ack & hit(address, `NSA_OFF_CTRL);
        trig_rise = s_q.trig_s2[s_q.tsel] & ~s_q.trig_prev;
        pause = irq_active & s_q.interrupt_mode_select;
        paired = (s_q.mode == NSA_CONC) || (s_q.mode == NSA_TRIG);
        cpu_stall = 1'h0;
        scan_access = 1'h0;
        // outputs follow state; accesses are withheld while frozen
        if (s_q.st == NSA_RUN)
        begin
            case (s_q.mode)
                NSA_BURST:
                begin
                    cpu_stall = ~pause;
                    scan_access = ~pause & ce;
                end
                NSA_PEEK:
                begin
                    scan_access = ~cpu_nvm_need & ~pause & ce;
                end
                default:
                begin
                    cpu_stall = ~pause;
                    scan_access = ~pause & ce;
                end
            endcase
        end
        if (ce)
        begin
            s_d.trig_s1 = trig_pins;
            s_d.trig_s2 = s_q.trig_s1;
            s_d.trig_prev = s_q.trig_s2[s_q.tsel];
            s_d.ack = req & ~s_q.ack;
            if (req & ~s_q.ack)
            begin
                s_d.rdata = `NSA_RST_WORD;
                if (hit(address, `NSA_OFF_CTRL))
                begin
                    s_d.rdata[`NSA_CTRL_GO] = s_q.go;
                    s_d.rdata[`NSA_CTRL_MODE_HI:`NSA_CTRL_MODE_LO] = s_q.mode;
                    s_d.rdata[`NSA_CTRL_INTERRUPT_MODE_SELECT] = s_q.interrupt_mode_select;
                    s_d.rdata[`NSA_CTRL_TSEL_HI:`NSA_CTRL_TSEL_LO] = s_q.tsel;
                end
                else if (hit(address, `NSA_OFF_STAT))
                begin
                    s_d.rdata[`NSA_STAT_BUSY] = s_q.go;
                    s_d.rdata[`NSA_STAT_ARMED] = (s_q.st == NSA_ARM);
                    s_d.rdata[`NSA_STAT_STALL] = cpu_stall;
                    s_d.rdata[`NSA_STAT_ST_HI:`NSA_STAT_ST_LO] = s_q.st;
                end
            end
            case (s_q.st)
                NSA_IDLE:
                begin
                    if (s_q.go)
                        s_d.st = (s_q.mode == NSA_TRIG) ? NSA_ARM : NSA_RUN;
                end
                NSA_ARM:
                begin
                    if (trig_rise)
                        s_d.st = NSA_RUN;
                end
                NSA_RUN:
                begin
                    if (scan_access & paired)
                        s_d.st = NSA_GAP;
                end
                NSA_GAP:
                begin
                    s_d.st = NSA_RUN;
                end
                default:
                begin
                    s_d.st = NSA_IDLE;
                end
            endcase
            if (!s_q.go)
                s_d.st = NSA_IDLE;
            if (scan_end)
            begin
                s_d.go = 1'h0;
                s_d.st = NSA_IDLE;
            end
            // a software write in the end cycle wins, so a restart is never lost
            if (wr_ctrl & byteenable[0])
            begin
                s_d.go = writedata[`NSA_CTRL_GO];
                s_d.mode = nsa_mode_t'(writedata[`NSA_CTRL_MODE_HI:`NSA_CTRL_MODE_LO]);
                s_d.interrupt_mode_select = writedata[`NSA_CTRL_INTERRUPT_MODE_SELECT];
                if (!writedata[`NSA_CTRL_GO])
                    s_d.st = NSA_IDLE;
                else if (s_q.st == NSA_IDLE || scan_end)
                begin
                    // in burst and concurrent modes the stall lands on the very next cycle; triggered mode arms first
                    if (writedata[`NSA_CTRL_MODE_HI:`NSA_CTRL_MODE_LO] == `NSA_MODE_TRIG)
                        s_d.st = NSA_ARM;
                    else
                        s_d.st = NSA_RUN;
                end
            end
            if (wr_ctrl & byteenable[1])
                s_d.tsel = writedata[`NSA_CTRL_TSEL_HI:`NSA_CTRL_TSEL_LO];
        end
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            s_q.go <= `NSA_RST_GO;
            s_q.mode <= nsa_mode_t'(`NSA_RST_MODE);
            s_q.interrupt_mode_select <= `NSA_RST_INTERRUPT_MODE_SELECT;
            s_q.tsel <= `NSA_RST_TSEL;
            s_q.st <= NSA_IDLE;
            s_q.trig_s1 <= `NSA_RST_TRIG;
            s_q.trig_s2 <= `NSA_RST_TRIG;
            s_q.trig_prev <= 1'h0;
            s_q.ack <= 1'h0;
            s_q.rdata <= `NSA_RST_WORD;
        end
        else
            s_q <= s_d;
    end

    assign readdata = s_q.rdata;
    // one wait cycle per access; frozen clock enable stretches it
    assign waitrequest = req & ~s_q.ack;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n_s);

    chk_burst_stall: assert property (
        (s_q.st == NSA_RUN && s_q.mode == NSA_BURST && !pause) |-> (cpu_stall && (scan_access == ce)))
    else $error("burst run without stall or access");

    chk_burst_start: assert property (
        (ce && wr_ctrl && byteenable[0] && writedata[`NSA_CTRL_GO] && !s_q.go
         && writedata[`NSA_CTRL_MODE_HI:`NSA_CTRL_MODE_LO] == `NSA_MODE_BURST && !irq_active)
        |=> (cpu_stall == !pause && s_q.st == NSA_RUN))
    else $error("burst stall not in the cycle after go");

    chk_burst_hold: assert property (
        (ce && s_q.st == NSA_RUN && s_q.mode == NSA_BURST && !scan_end && !wr_ctrl)
        |=> (s_q.st == NSA_RUN && s_q.go))
    else $error("burst released without end condition");

    chk_conc_gap: assert property (
        (ce && scan_access && paired && !scan_end && !wr_ctrl)
        |=> ((!cpu_stall && !scan_access && s_q.st == NSA_GAP)
            and ((ce && !scan_end && !wr_ctrl) |=> (s_q.st == NSA_RUN))))
    else $error("concurrent mode gave cpu no gap");

    chk_conc_pair: assert property (
        (s_q.st == NSA_RUN && paired) |-> (cpu_stall == (scan_access || (!ce && !pause))))
    else $error("concurrent stall not tied to access");

    chk_trig_wait: assert property (
        (s_q.st == NSA_ARM) |-> (!scan_access && !cpu_stall))
    else $error("access before trigger edge");

    chk_trig_start: assert property (
        (ce && s_q.st == NSA_ARM && trig_rise && s_q.go && !scan_end && !wr_ctrl && !irq_active)
        |=> (s_q.st == NSA_RUN && scan_access == (ce && !pause) && cpu_stall == !pause))
    else $error("first triggered access late");

    chk_peek_free: assert property (
        (s_q.mode == NSA_PEEK) |-> !cpu_stall)
    else $error("peek mode stalled the cpu");

    chk_peek_dead: assert property (
        (ce && s_q.st == NSA_RUN && s_q.mode == NSA_PEEK && !pause) |-> (scan_access == !cpu_nvm_need))
    else $error("peek access not in dead cycle");

    chk_int_pause: assert property (
        (s_q.interrupt_mode_select && irq_active) |-> (!scan_access && !cpu_stall))
    else $error("scan not paused for interrupt");

    chk_int_keep: assert property (
        (!s_q.interrupt_mode_select && ce && s_q.st == NSA_RUN && s_q.mode != NSA_PEEK) |-> (scan_access && cpu_stall))
    else $error("scan dropped during interrupt");

    chk_end_idle: assert property (
        (ce && scan_end && !wr_ctrl) |=> (!s_q.go && s_q.st == NSA_IDLE && !cpu_stall && !scan_access))
    else $error("end condition did not idle the arbiter");

    chk_bus_wait: assert property (
        (ce && req && !s_q.ack) |=> (!waitrequest || !req))
    else $error("bus answer not after one wait cycle");

    cov_burst_end: cover property (
        (s_q.st == NSA_RUN && s_q.mode == NSA_BURST && cpu_stall) [*3] ##1 scan_end);
    cov_trig_go: cover property (
        (s_q.st == NSA_ARM) ##1 (s_q.st == NSA_ARM && trig_rise) ##1 scan_access);
    cov_peek_wait: cover property (
        (s_q.mode == NSA_PEEK && s_q.st == NSA_RUN && cpu_nvm_need) ##1 scan_access);
    cov_irq_pause: cover property (
        (s_q.st == NSA_RUN && s_q.interrupt_mode_select && irq_active) ##1 scan_access);
endmodule

// ==== nsa_cpu_model.sv ====
// cpu core model: fetch with a dead cycle every third, interrupt response
`timescale 1ns/1ps
module nsa_cpu_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cpu_stall,
    input wire logic irq_req,
    output logic cpu_nvm_need,
    output logic irq_active
);
    logic [1:0] ph_q;
    // a stalled cpu fetches nothing, so its phase stands still
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ph_q <= 2'h0;
            irq_active <= 1'h0;
        end
        else
        begin
            if (!cpu_stall)
                ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            irq_active <= irq_req;
        end
    end
    assign cpu_nvm_need = (ph_q != 2'h2);
endmodule

// ==== tb.sv ====
// self-checking bench of the scanner arbiter
`timescale 1ns/1ps
module tb;
    logic clk, rstn, ce, read, write, scan_end, irq_req, cpu_stall, scan_access, waitrequest, cpu_nvm_need, irq_active;
    logic [3:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [15:0] trig_pins;
    int n_errors, cmp_count;
    nsa_arbiter nsa_arbiter_inst (.clk(clk), .rstn(rstn), .ce(ce), .address(address), .read(read),
        .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .trig_pins(trig_pins), .cpu_nvm_need(cpu_nvm_need), .irq_active(irq_active), .scan_end(scan_end),
        .cpu_stall(cpu_stall), .scan_access(scan_access));
    nsa_cpu_model nsa_cpu_model_inst (.clk(clk), .rstn(rstn), .cpu_stall(cpu_stall), .irq_req(irq_req),
        .cpu_nvm_need(cpu_nvm_need), .irq_active(irq_active));
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // an edge passes first so a release and a new request never share a time step
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int g;
        g = 0;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do
        begin
            @(posedge clk);
            g++;
        end
        while (waitrequest !== 1'b0);
        rd = readdata;
        chk(g == 2, "bus wait count");
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic stop_scan();
        scan_end <= 1'b1;
        @(posedge clk);
        scan_end <= 1'b0;
        @(posedge clk);
        chk(cpu_stall === 1'b0 && scan_access === 1'b0, "not idle after end");
        bus(1'b0, 4'h4, 32'h0);
        chk(rd[0] === 1'b0 && rd[7:4] === 4'h1, "go not cleared");
    endtask
    task automatic t_regs();
        bus(1'b0, 4'h0, 32'h0);
        chk(rd === 32'h0, "ctrl reset value");
        bus(1'b1, 4'h0, 32'hFFFF_FF38);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd === 32'h0000_0F08, "ctrl readback");
        bus(1'b1, 4'h8, 32'hFFFF_FFFF);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        bus(1'b1, 4'h0, 32'h0);
    endtask
    task automatic t_burst();
        bus(1'b1, 4'h0, 32'h3);
        chk(cpu_stall === 1'b0, "stall too early");
        repeat (6)
        begin
            @(posedge clk);
            chk(cpu_stall === 1'b1 && scan_access === 1'b1, "burst not holding");
        end
        bus(1'b0, 4'h4, 32'h0);
        chk(rd === 32'h0000_0045, "burst status");
        stop_scan();
    endtask
    // frozen clock enable must withhold accesses but keep the burst stall
    task automatic t_freeze();
        bus(1'b1, 4'h0, 32'h3);
        ce <= 1'b0;
        repeat (4)
        begin
            @(posedge clk);
            chk(scan_access === 1'b0 && cpu_stall === 1'b1, "frozen burst moved");
        end
        ce <= 1'b1;
        @(posedge clk);
        chk(scan_access === 1'b1 && cpu_stall === 1'b1, "burst lost after freeze");
        stop_scan();
    endtask
    task automatic t_conc();
        logic p;
        bus(1'b1, 4'h0, 32'h1);
        @(posedge clk);
        p = scan_access;
        chk(p === 1'b1 && cpu_stall === 1'b1, "no first access");
        repeat (7)
        begin
            @(posedge clk);
            chk(cpu_stall === scan_access && scan_access !== p, "conc pattern");
            p = scan_access;
        end
        stop_scan();
    endtask
    task automatic t_trig();
        int g;
        g = 0;
        bus(1'b1, 4'h0, 32'h207);
        trig_pins <= 16'h0001;
        repeat (6)
        begin
            @(posedge clk);
            chk(scan_access === 1'b0 && cpu_stall === 1'b0, "scan before trigger");
        end
        bus(1'b0, 4'h4, 32'h0);
        chk(rd === 32'h0000_0023, "armed status");
        trig_pins <= 16'h0005;
        do
        begin
            @(posedge clk);
            g++;
        end
        while (scan_access !== 1'b1 && g < 10);
        chk(g < 6 && cpu_stall === 1'b1, "trigger latency");
        @(posedge clk);
        chk(cpu_stall === 1'b0, "cpu not resumed");
        trig_pins <= 16'h0000;
        stop_scan();
    endtask
    task automatic t_peek();
        logic f;
        f = 1'b1;
        bus(1'b1, 4'h0, 32'h5);
        repeat (12)
        begin
            @(posedge clk);
            chk(cpu_stall === 1'b0 && !(scan_access === 1'b1 && cpu_nvm_need === 1'b1), "peek hit cpu");
            if (f && cpu_nvm_need === 1'b0)
            begin
                chk(scan_access === 1'b1, "first dead cycle missed");
                f = 1'b0;
            end
        end
        stop_scan();
    endtask
    task automatic t_irq();
        bus(1'b1, 4'h0, 32'hB);
        irq_req <= 1'b1;
        repeat (3) @(posedge clk);
        chk(cpu_stall === 1'b0 && scan_access === 1'b0, "burst not paused");
        irq_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk(cpu_stall === 1'b1, "burst not resumed");
        stop_scan();
        bus(1'b1, 4'h0, 32'h3);
        irq_req <= 1'b1;
        repeat (3) @(posedge clk);
        chk(cpu_stall === 1'b1 && scan_access === 1'b1, "burst yielded");
        irq_req <= 1'b0;
        stop_scan();
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #(20 * 3000);
        n_errors++;
        tally_and_finish();
    end
    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        scan_end = 1'b0;
        irq_req = 1'b0;
        trig_pins = 16'h0000;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_burst();
        t_conc();
        t_trig();
        t_peek();
        t_irq();
        t_freeze();
        tally_and_finish();
    end
endmodule
